/* File: rtl/dtc_pkg.sv */
package dtc_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] DTC_OFS_MODE  = 8'h00;
    localparam logic [7:0] DTC_OFS_RUN   = 8'h04;
    localparam logic [7:0] DTC_OFS_LO0   = 8'h08;
    localparam logic [7:0] DTC_OFS_HI0   = 8'h0c;
    localparam logic [7:0] DTC_OFS_LO1   = 8'h10;
    localparam logic [7:0] DTC_OFS_HI1   = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DTC_NIB_W   = 4;
    localparam int DTC_GATE    = 3;
    localparam int DTC_CT      = 2;
    localparam int DTC_OVF_1   = 7;
    localparam int DTC_RUN_1   = 6;
    localparam int DTC_OVF_0   = 5;
    localparam int DTC_RUN_0   = 4;
    localparam logic [7:0] DTC_RUN_MASK = 8'hf0;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] DTC_MODE_RST = 8'h00;
    localparam logic [7:0] DTC_RUN_RST  = 8'h00;
    localparam logic [7:0] DTC_CNT_RST  = 8'h00;
    localparam int DTC_CLK_NS   = 100;
    localparam int DTC_MC_CLKS  = 12;
    localparam int DTC_MC_NS    = DTC_CLK_NS * DTC_MC_CLKS;
    localparam int DTC_EDGE_MC  = 2;

    typedef enum logic [1:0] {
        DTC_M13   = 2'b00,
        DTC_M16   = 2'b01,
        DTC_MRLD  = 2'b10,
        DTC_MSPLT = 2'b11
    } dtc_mode_t;

endpackage

/* File: rtl/dtc_sync.sv */
`timescale 1ns/1ps
module dtc_sync
    import dtc_pkg::*;
#(
    parameter int W = 4
)
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } dtc_sync_t;

    dtc_sync_t s_q;
    dtc_sync_t s_d;

    // ------------------------------------------------------------
    // Three stages; a change counts once stages two and three agree
    // ------------------------------------------------------------
    always_comb
    begin
        s_d    = s_q;
        s_d.s1 = pin;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        for (int i = 0; i < W; i++)
        begin
            if (s_q.s2[i] == s_q.s3[i])
            begin
                s_d.lvl[i] = s_q.s3[i];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign level = s_q.lvl;

endmodule

/* File: rtl/dtc_top.sv */
`timescale 1ns/1ps
// Overview of operation
// RL1: two timers, each 16-bit low/high byte
// RL2: timer mode increments every 12 clocks
// RL3: counter mode increments on input falling edge
// RL4: falling edge recognised over two machine cycles
// RL5: count input stable one machine cycle minimum
// RL6: run bits start their timers
// RL7: gate set: count only while gate pin high
// RL8: count-source bit picks counter or timer
// RL9: two mode bits per timer select mode
// RL10: mode 0: 13-bit, low byte top cleared
// RL11: mode 2: low byte reloads from high
// RL12: timer 1 in mode 3 stops
// RL13: timer 0 mode 3 splits into bytes
// RL14: split high byte uses timer 1 controls
// RL15: overflow flags set, software/ack clear
// RL16: clearing run bit stops the timer
// RL17: no timer0 mode2 with timer1 mode0/1
// RL18: all state clears on reset; the bus ready flag (hreadyout) resets to 1
module dtc_top
    import dtc_pkg::*;
#(
    parameter int MC_CLKS = DTC_MC_CLKS
)
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    input  wire logic        count_input_0,
    input  wire logic        count_input_1,
    input  wire logic        gate_pin_0,
    input  wire logic        gate_pin_1,
    input  wire logic        irq_ack_0,
    input  wire logic        irq_ack_1,
    output logic             overflow_flag_0,
    output logic             overflow_flag_1
);

    localparam int PRE_W = $clog2(MC_CLKS);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MC_CLKS - 1);

    typedef struct packed {
        logic [7:0]       mode_ctl;
        logic [7:0]       run_ctl;
        logic [1:0][7:0]  cnt_lo;                                      // RL1
        logic [1:0][7:0]  cnt_hi;
        logic [PRE_W-1:0] pre;
        logic             mc_tick;
        logic [1:0][1:0]  samp;
        logic             dp_valid;
        logic             dp_write;
        logic [7:0]       dp_addr;
        logic [31:0]      rdata;
        logic             ready;
    } dtc_state_t;

    localparam dtc_state_t S_RST = '{ready: 1'b1, default: '0};

    dtc_state_t s_q;
    dtc_state_t s_d;

    logic [3:0]  pin_lvl;
    logic [1:0]  cin;
    logic [1:0]  gin;
    logic [1:0]  en;
    logic [1:0]  tick;
    logic [1:0]  set_ovf;
    logic        wr_en;
    logic        wr_cnt;
    logic        split;
    logic [3:0]  nib;
    logic [16:0] stp;
    logic [8:0]  hi_inc;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    dtc_sync #(.W(4)) u_sync (
        .clk   (clk),
        .rst   (rst),
        .pin   ({gate_pin_1, gate_pin_0, count_input_1, count_input_0}),
        .level (pin_lvl)
    );

    assign cin = pin_lvl[1:0];
    assign gin = pin_lvl[3:2];

    // Returns {overflow, high, low} after one count step
    function automatic logic [16:0] step(input logic [1:0] m,
                                         input logic [7:0] lo,
                                         input logic [7:0] hi);
        logic [13:0] v13;
        logic [16:0] v16;
        logic [8:0]  v8;
        v13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        v16 = {1'b0, hi, lo} + 17'h00001;
        v8  = {1'b0, lo} + 9'h001;
        unique case (m)
            DTC_M13:  step = {v13[13], v13[12:5], 3'b000, v13[4:0]};   // RL10
            DTC_M16:  step = v16;                                      // RL9
            DTC_MRLD: step = {v8[8], hi, v8[8] ? hi : v8[7:0]};        // RL11
            default:  step = {v8[8], hi, v8[7:0]};                     // RL13
        endcase
    endfunction

    function automatic logic [31:0] rd(input dtc_state_t s, input logic [7:0] a);
        unique case (a)
            DTC_OFS_MODE: rd = {24'h000000, s.mode_ctl};
            DTC_OFS_RUN:  rd = {24'h000000, s.run_ctl};
            DTC_OFS_LO0:  rd = {24'h000000, s.cnt_lo[0]};
            DTC_OFS_HI0:  rd = {24'h000000, s.cnt_hi[0]};
            DTC_OFS_LO1:  rd = {24'h000000, s.cnt_lo[1]};
            DTC_OFS_HI1:  rd = {24'h000000, s.cnt_hi[1]};
            default:      rd = 32'h00000000;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        s_d     = s_q;
        set_ovf = 2'b00;
        en      = 2'b00;
        tick    = 2'b00;
        nib     = 4'h0;
        stp     = 17'h00000;
        hi_inc  = 9'h000;
        split   = (s_q.mode_ctl[1:0] == DTC_MSPLT);
        wr_en   = s_q.dp_valid && s_q.dp_write;
        wr_cnt  = wr_en && (s_q.dp_addr != DTC_OFS_MODE) && (s_q.dp_addr != DTC_OFS_RUN);

        // Machine-cycle prescaler
        s_d.mc_tick = (s_q.pre == PRE_LAST);                           // RL2
        s_d.pre     = s_d.mc_tick ? '0 : s_q.pre + PRE_W'(1);

        for (int i = 0; i < 2; i++)
        begin
            nib = s_q.mode_ctl[i*DTC_NIB_W +: DTC_NIB_W];
            if (s_q.mc_tick)
            begin
                s_d.samp[i] = {s_q.samp[i][0], cin[i]};                // RL4 RL5
            end
            en[i]   = s_q.run_ctl[DTC_RUN_0 + 2*i]                     // RL6 RL16
                      && (!nib[DTC_GATE] || gin[i]);                   // RL7
            tick[i] = s_q.mc_tick && en[i]
                      && (nib[DTC_CT] ? (s_q.samp[i][1] && !s_q.samp[i][0])  // RL3 RL8
                                      : 1'b1);                         // RL2
            stp = step(nib[1:0], s_q.cnt_lo[i], s_q.cnt_hi[i]);
            if (tick[i] && !(i == 1 && nib[1:0] == DTC_MSPLT))         // RL12
            begin
                s_d.cnt_lo[i] = stp[7:0];
                s_d.cnt_hi[i] = stp[15:8];
                if (!(i == 1 && split))
                begin
                    set_ovf[i] = stp[16];                              // RL15
                end
            end
        end

        // Split high byte counts machine cycles under the second run bit
        if (split && s_q.mc_tick && s_q.run_ctl[DTC_RUN_1])            // RL14
        begin
            hi_inc        = {1'b0, s_q.cnt_hi[0]} + 9'h001;
            s_d.cnt_hi[0] = hi_inc[7:0];
            set_ovf[1]    = hi_inc[8];                                 // RL14
        end

        // Register writes land in the data phase
        if (wr_en)
        begin
            unique case (s_q.dp_addr)
                DTC_OFS_MODE: s_d.mode_ctl  = hwdata[7:0];
                DTC_OFS_RUN:  s_d.run_ctl   = hwdata[7:0] & DTC_RUN_MASK;
                DTC_OFS_LO0:  s_d.cnt_lo[0] = hwdata[7:0];
                DTC_OFS_HI0:  s_d.cnt_hi[0] = hwdata[7:0];
                DTC_OFS_LO1:  s_d.cnt_lo[1] = hwdata[7:0];
                DTC_OFS_HI1:  s_d.cnt_hi[1] = hwdata[7:0];
                default:      s_d.rdata     = s_q.rdata;
            endcase
        end

        // Service acknowledge clears; a hardware set wins over any clear
        if (irq_ack_0)
        begin
            s_d.run_ctl[DTC_OVF_0] = 1'b0;                             // RL15
        end
        if (irq_ack_1)
        begin
            s_d.run_ctl[DTC_OVF_1] = 1'b0;
        end
        if (set_ovf[0])
        begin
            s_d.run_ctl[DTC_OVF_0] = 1'b1;                             // RL15
        end
        if (set_ovf[1])
        begin
            s_d.run_ctl[DTC_OVF_1] = 1'b1;                             // RL15
        end

        // Mode 0 holds the top three low-byte bits at zero
        for (int i = 0; i < 2; i++)
        begin
            if (s_d.mode_ctl[i*DTC_NIB_W +: 2] == DTC_M13)
            begin
                s_d.cnt_lo[i][7:5] = 3'b000;                           // RL10
            end
        end

        // Address phase: zero-wait slave, read data prepared now
        s_d.ready    = 1'b1;
        s_d.dp_valid = hsel && hready && htrans[1];
        s_d.dp_write = hwrite;
        s_d.dp_addr  = (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hff;
        if (s_d.dp_valid && !hwrite)
        begin
            s_d.rdata = rd(s_q, s_d.dp_addr);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_q <= S_RST;                                              // RL18
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign hreadyout       = s_q.ready;
    assign hrdata          = s_q.rdata;
    assign hresp           = 1'b0;
    assign overflow_flag_0 = s_q.run_ctl[DTC_OVF_0];
    assign overflow_flag_1 = s_q.run_ctl[DTC_OVF_1];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic unused_sz;
    assign unused_sz = ^hsize;

    tick_period_a: assert property (s_q.mc_tick |=> !s_q.mc_tick [*8] ##1 !s_q.mc_tick [*3] ##1 s_q.mc_tick) // RL2
        else $error("machine cycle tick not every 12 clocks");

    timer_inc_a: assert property (s_q.mode_ctl[3:0] == 4'h1 && tick[0] && !wr_en
        && {s_q.cnt_hi[0], s_q.cnt_lo[0]} != 16'hffff
        |=> {s_q.cnt_hi[0], s_q.cnt_lo[0]}
            == $past({s_q.cnt_hi[0], s_q.cnt_lo[0]}) + 16'h0001) // RL2
        else $error("16-bit timer did not step by one");

    edge_only_a: assert property (s_q.mode_ctl[2] && s_q.mode_ctl[1:0] == 2'b01 && !wr_en
        && !(s_q.mc_tick && s_q.samp[0][1] && !s_q.samp[0][0])
        |=> $stable(s_q.cnt_lo[0])) // RL3
        else $error("counter moved without a falling edge");

    run_stop_a: assert property (!s_q.run_ctl[DTC_RUN_0] && !wr_en
        |=> $stable(s_q.cnt_lo[0])) // RL16
        else $error("timer 0 counted while stopped");

    gate_hold_a: assert property (s_q.mode_ctl[DTC_GATE] && !gin[0] && !wr_en
        |=> $stable(s_q.cnt_lo[0])) // RL7
        else $error("timer 0 counted with gate low");

    mode0_top_a: assert property (s_q.mode_ctl[1:0] == DTC_M13
        |=> $past(s_q.mode_ctl[1:0]) != DTC_M13 || s_q.cnt_lo[0][7:5] == 3'b000) // RL10
        else $error("mode 0 top bits not cleared");

    reload_a: assert property (s_q.mode_ctl[1:0] == DTC_MRLD && tick[0] && !wr_en
        && s_q.cnt_lo[0] == 8'hff
        |=> s_q.cnt_lo[0] == $past(s_q.cnt_hi[0]) && s_q.run_ctl[DTC_OVF_0]) // RL11
        else $error("auto-reload or flag missing");

    t1_stop_a: assert property (s_q.mode_ctl[5:4] == DTC_MSPLT && !wr_en
        |=> $stable({s_q.cnt_hi[1], s_q.cnt_lo[1]})) // RL12
        else $error("timer 1 counted in mode 3");

    split_hi_a: assert property (split && s_q.mc_tick && s_q.run_ctl[DTC_RUN_1]
        && s_q.cnt_hi[0] == 8'hff && !wr_en
        |=> s_q.cnt_hi[0] == 8'h00 && s_q.run_ctl[DTC_OVF_1]) // RL14
        else $error("split high byte overflow wrong");

    flag_set_a: assert property (set_ovf[0] |=> overflow_flag_0) // RL15
        else $error("overflow flag 0 lost");

    reset_clr_a: assert property (@(posedge clk) disable iff (1'b0) rst |=> s_q.mode_ctl == DTC_MODE_RST
        && s_q.run_ctl == DTC_RUN_RST && s_q.cnt_lo == '0 && s_q.cnt_hi == '0) // RL18
        else $error("state not cleared by reset");

    split_cv: cover property (split && set_ovf[1]);
    reload_cv: cover property (s_q.mode_ctl[1:0] == DTC_MRLD && set_ovf[0]);
    edge_cv: cover property (s_q.mode_ctl[2] && tick[0]);

endmodule

/* File: tb/dtc_pins.sv */
`timescale 1ns/1ps
module dtc_pins
(
    input  wire logic clk,
    output logic      count_input_0,
    output logic      count_input_1,
    output logic      gate_pin_0,
    output logic      gate_pin_1
);
    logic [1:0] cin_q = 2'b11;
    logic [1:0] gate_q = 2'b00;
    assign count_input_0 = cin_q[0];
    assign count_input_1 = cin_q[1];
    assign gate_pin_0    = gate_q[0];
    assign gate_pin_1    = gate_q[1];

    // Count pins rest high; each level held two machine cycles
    task automatic pulse(input int idx, input int n);
        repeat (n)
        begin
            cin_q[idx] <= 1'b0;
            repeat (24) @(posedge clk);
            cin_q[idx] <= 1'b1;
            repeat (24) @(posedge clk);
        end
    endtask

    task automatic gate(input int idx, input logic v);
        gate_q[idx] <= v;
        @(posedge clk);
    endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import dtc_pkg::*;
    logic        clk, rst, hsel, hwrite, hreadyout, hresp;
    logic        ack0, ack1, f0, f1, ci0, ci1, gp0, gp1;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  v, w;
    int          error_cnt, checks_done;

    dtc_top #(.MC_CLKS(DTC_MC_CLKS)) dut (.clk(clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .count_input_0(ci0),
        .count_input_1(ci1), .gate_pin_0(gp0), .gate_pin_1(gp1),
        .irq_ack_0(ack0), .irq_ack_1(ack1), .overflow_flag_0(f0),
        .overflow_flag_1(f1));
    dtc_pins pins (.clk(clk), .count_input_0(ci0), .count_input_1(ci1),
        .gate_pin_0(gp0), .gate_pin_1(gp1));

    // --------
    // Helpers
    // --------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic inr(input logic [7:0] x, input logic [7:0] lo, input logic [7:0] hi);
        check(8'(x >= lo && x <= hi), 8'h01);
    endtask
    task automatic bus(input logic wt, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] r);
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wt;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata[7:0];
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        bus(1'b0, a, 8'h00, r);
    endtask
    task automatic mc(input int n);
        repeat (n * DTC_MC_CLKS) @(posedge clk);
    endtask
    task automatic fl(input logic e0, input logic e1);
        #1;
        check(8'(f0), 8'(e0));
        check(8'(f1), 8'(e1));
        @(posedge clk);
    endtask

    // --------
    // Scenarios
    // --------
    task automatic t_reset();
        wr(8'h18, 8'hff);
        for (int i = 0; i < 7; i++)
        begin
            rd(8'(i * 4), v);
            check(v, 8'h00);
        end
        fl(1'b0, 1'b0);
    endtask
    task automatic t_mode1();
        wr(DTC_OFS_MODE, 8'h01);
        wr(DTC_OFS_LO0, 8'hff);
        wr(DTC_OFS_HI0, 8'hff);
        wr(DTC_OFS_RUN, 8'h10);
        mc(2);
        fl(1'b1, 1'b0);
        rd(DTC_OFS_RUN, v);
        check(v, 8'h30);
        rd(DTC_OFS_HI0, v);
        check(v, 8'h00);
        ack0 <= 1'b1;
        @(posedge clk);
        ack0 <= 1'b0;
        @(posedge clk);
        fl(1'b0, 1'b0);
        wr(DTC_OFS_RUN, 8'h00);
        rd(DTC_OFS_LO0, v);
        mc(3);
        rd(DTC_OFS_LO0, w);
        check(w, v);
        wr(DTC_OFS_LO0, 8'h00);
        wr(DTC_OFS_RUN, 8'h10);
        mc(100);
        wr(DTC_OFS_RUN, 8'h00);
        rd(DTC_OFS_LO0, v);
        inr(v, 8'h64, 8'h65);
    endtask
    task automatic t_mode0();
        wr(DTC_OFS_MODE, 8'h00);
        wr(DTC_OFS_LO0, 8'hff);
        rd(DTC_OFS_LO0, v);
        check(v, 8'h1f);
        wr(DTC_OFS_HI0, 8'hff);
        wr(DTC_OFS_RUN, 8'h10);
        mc(2);
        fl(1'b1, 1'b0);
        rd(DTC_OFS_HI0, v);
        check(v, 8'h00);
        wr(DTC_OFS_RUN, 8'h00);
    endtask
    task automatic t_mode2();
        wr(DTC_OFS_MODE, 8'h22);
        wr(DTC_OFS_HI0, 8'h80);
        wr(DTC_OFS_LO0, 8'hff);
        wr(DTC_OFS_RUN, 8'h10);
        mc(2);
        fl(1'b1, 1'b0);
        wr(DTC_OFS_RUN, 8'h00);
        rd(DTC_OFS_LO0, v);
        inr(v, 8'h80, 8'h83);
        rd(DTC_OFS_HI0, v);
        check(v, 8'h80);
    endtask
    task automatic t_count();
        wr(DTC_OFS_MODE, 8'hd5);
        wr(DTC_OFS_LO0, 8'h00);
        wr(DTC_OFS_LO1, 8'h00);
        wr(DTC_OFS_RUN, 8'h50);
        pins.pulse(0, 3);
        pins.pulse(1, 3);
        rd(DTC_OFS_LO0, v);
        check(v, 8'h03);
        rd(DTC_OFS_LO1, v);
        check(v, 8'h00);
        pins.gate(1, 1'b1);
        pins.pulse(1, 2);
        rd(DTC_OFS_LO1, v);
        check(v, 8'h02);
        wr(DTC_OFS_RUN, 8'h00);
        pins.pulse(1, 2);
        rd(DTC_OFS_LO1, v);
        check(v, 8'h02);
    endtask
    task automatic t_mode3();
        wr(DTC_OFS_MODE, 8'h33);
        wr(DTC_OFS_LO0, 8'hff);
        wr(DTC_OFS_HI0, 8'hff);
        wr(DTC_OFS_LO1, 8'h05);
        wr(DTC_OFS_RUN, 8'h50);
        mc(2);
        fl(1'b1, 1'b1);
        ack1 <= 1'b1;
        @(posedge clk);
        ack1 <= 1'b0;
        @(posedge clk);
        fl(1'b1, 1'b0);
        rd(DTC_OFS_LO1, v);
        check(v, 8'h05);
        wr(DTC_OFS_RUN, 8'h40);
        rd(DTC_OFS_LO0, v);
        rd(DTC_OFS_HI0, w);
        inr(w, 8'h00, 8'h03);
        mc(3);
        rd(DTC_OFS_HI0, w);
        inr(w, 8'h03, 8'h07);
        rd(DTC_OFS_LO0, w);
        check(w, v);
    endtask

    task automatic give_verdict();
        $display("errors %0d, checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
    initial
    begin
        {rst, hsel, hwrite, ack0, ack1} = 5'b11000;
        {haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'b010};
        error_cnt = 0;
        checks_done = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_mode1();
        t_mode0();
        t_mode2();
        t_count();
        t_mode3();
        give_verdict();
    end
endmodule
